// ==== rtl/tfc_regs.svh ====
// register offsets, field positions, reset values and timing of the t1 framer control block
`ifndef TFC_REGS_SVH
`define TFC_REGS_SVH

`define TFC_ADDR_STATUS 8'h20
`define TFC_ADDR_RX_SYNC 8'h2B
`define TFC_ADDR_RX_OPT 8'h2C
`define TFC_ADDR_TX_FMT 8'h35
`define TFC_ADDR_COMMON1 8'h37
`define TFC_ADDR_COMMON2 8'h38
`define TFC_RESET_VALUE 8'h00
`define TFC_READ_ZERO 8'h00

`define TFC_RS_VCF 7
`define TFC_RS_CRIT 6
`define TFC_RS_OOFA 5
`define TFC_RS_OOFB 4
`define TFC_RS_SYNC_CRITERIA 3
`define TFC_RS_SYNC_TIME 2
`define TFC_RS_AUTODIS 1
`define TFC_RS_MANUAL 0
`define TFC_RO_CODE 7
`define TFC_RO_ZBTSI 6
`define TFC_RO_DWIDE 5
`define TFC_RO_MODE 4
`define TFC_RO_DIR 3
`define TFC_RO_YEL 2
`define TFC_RO_FSREP 1
`define TFC_RO_MFCF 0
`define TFC_TX_FALLBACK 7
`define TFC_TX_FPT 6
`define TFC_TX_CPT 5
`define TFC_TX_ROBBED_BIT_SIGNALLING_ENABLE 4
`define TFC_TX_GSTUFF 3
`define TFC_TX_LINKSRC 2
`define TFC_TX_BLUE 1
`define TFC_TX_YEL 0
`define TFC_C1_RESE 2
`define TFC_C2_RFM 3
`define TFC_ST_INSYNC 0
`define TFC_ST_FALLBACK 1

`define TFC_OOF_ERRS 3'h2
`define TFC_OOF_WIN_A 3'h4
`define TFC_OOF_WIN_B 3'h5
`define TFC_OOF_WIN_C 3'h6
`define TFC_QUAL_SHORT 5'h0A
`define TFC_QUAL_LONG 5'h18
`define TFC_IDLE_CODE 8'h7F
`define TFC_CHANNELS 24
`define TFC_CLOCK_MHZ 200
`define TFC_TX_STALL_NS 1000
`define TFC_TX_STALL_CYC ((`TFC_TX_STALL_NS * `TFC_CLOCK_MHZ + 999) / 1000)

`endif

// ==== rtl/tfc_pkg.sv ====
// types shared by the t1 framer control block
package tfc_pkg;

  typedef enum logic [1:0] {
    TFC_SEARCH = 2'b00,
    TFC_QUALIFY = 2'b01,
    TFC_INSYNC = 2'b11
  } tfc_state_t;

  typedef enum logic [1:0] {
    TFC_D4_SEQUENTIAL = 2'b00,
    TFC_D4_CROSS = 2'b01,
    TFC_ESF_FPS = 2'b10,
    TFC_ESF_CRC = 2'b11
  } tfc_search_t;

  typedef struct packed {
    logic chipSelectN;
    logic readN;
    logic writeN;
    logic [7:0] addr;
    logic [7:0] data;
  } tfc_pins_t;

  typedef struct packed {
    logic [7:0] rxSync;
    logic [7:0] rxOpt;
    logic [7:0] txFmt;
    logic [7:0] common1;
    logic [7:0] common2;
    logic resyncTog;
  } tfc_cfg_t;

  typedef struct packed {
    logic fbitValid;
    logic fbitErr;
    logic fbitIsFs;
    logic candidateFound;
    logic crcMatch;
    logic carrierLoss;
    logic lcvPulse;
    logic exzPulse;
    logic framePulse;
    logic multiframePulse;
    logic signallingFrame;
    logic chanStrobe;
    logic bit2Strobe;
    logic bit2Value;
    logic frame12SBitValid;
    logic sBitValue;
  } tfc_rx_ev_t;

  typedef struct packed {
    logic [4:0] channel;
    logic chanAllZero;
    logic [23:0] transparent;
    logic fdlRegBit;
    logic linkPinBit;
    logic posIn;
    logic negIn;
  } tfc_tx_in_t;

  typedef struct packed {
    logic framingFromSerial;
    logic crcFromSerial;
    logic insertSignalling;
    logic stuffBit7;
    logic linkBit;
    logic sendYellow;
  } tfc_tx_ctl_t;

  typedef struct packed {
    logic inSync;
    tfc_search_t searchMode;
    logic resyncStart;
    logic outOfFrame;
    logic zbtsiEnable;
    logic yellowAlarm;
    logic [7:0] subByte;
    logic syncLevelIn;
  } tfc_rx_stat_t;

endpackage : tfc_pkg

// ==== rtl/tfc_framer_control.sv ====
// control registers and control-driven receive and transmit logic of one t1 framer
`timescale 1ns/10ps
`include "tfc_regs.svh"

module tfc_framer_control import tfc_pkg::*; #(
  parameter int CNT_W = 16,
  parameter int STALL_CYC = `TFC_TX_STALL_CYC
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // parallel control port
  input wire logic busChipSelectN,
  input wire logic busReadN,
  input wire logic busWriteN,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  // transmit clock watch
  input wire logic transmitLineClock,
  output logic txUseRecovered,
  // line side
  input wire logic lineClock,
  input wire tfc_rx_ev_t rxEv,
  input wire tfc_tx_in_t txIn,
  input wire logic receiveSyncPinIn,
  output logic receiveSyncPinOut,
  output logic receiveSyncPinOe,
  output tfc_rx_stat_t rxStat,
  output logic [CNT_W-1:0] lcvCount,
  output logic [CNT_W-1:0] pathCount,
  output logic [CNT_W-1:0] multiframeCount,
  output tfc_tx_ctl_t txCtl,
  output logic lineOutPositive,
  output logic lineOutNegative
);

  // ----------------------------------------
  // system domain state
  // ----------------------------------------
  typedef struct packed {
    tfc_pins_t pinS1;
    tfc_pins_t pinS2;
    tfc_pins_t pinS3;
    tfc_pins_t pin;
    logic wrPrev;
    tfc_cfg_t cfg;
    logic [7:0] rdData;
    logic [2:0] txClkS;
    logic txClkLevel;
    logic [15:0] stallCnt;
    logic useRecovered;
    logic [2:0] syncS;
    logic inSync;
  } tfc_sys_t;

  tfc_sys_t s, next_s;
  logic writeNow;

  always_comb begin
    next_s = s;
    writeNow = 1'b0;
    next_s.pinS1 = {busChipSelectN, busReadN, busWriteN, busAddr, busDataIn};
    next_s.pinS2 = s.pinS1;
    next_s.pinS3 = s.pinS2;
    // pins count only once the last two stages agree
    if (s.pinS2 == s.pinS3) begin
      next_s.pin = s.pinS3;
    end
    next_s.wrPrev = !s.pin.chipSelectN && !s.pin.writeN;
    writeNow = !s.pin.chipSelectN && !s.pin.writeN && !s.wrPrev;
    if (writeNow) begin
      unique case (s.pin.addr)
        `TFC_ADDR_RX_SYNC: begin
          next_s.cfg.rxSync = s.pin.data;
          if (!s.cfg.rxSync[`TFC_RS_MANUAL] && s.pin.data[`TFC_RS_MANUAL]) begin
            next_s.cfg.resyncTog = !s.cfg.resyncTog;
          end
        end
        `TFC_ADDR_RX_OPT: next_s.cfg.rxOpt = s.pin.data;
        `TFC_ADDR_TX_FMT: next_s.cfg.txFmt = s.pin.data;
        `TFC_ADDR_COMMON1: next_s.cfg.common1 = s.pin.data;
        `TFC_ADDR_COMMON2: next_s.cfg.common2 = s.pin.data;
        default: ;
      endcase
    end
    unique case (s.pin.addr)
      `TFC_ADDR_STATUS: begin
        next_s.rdData = `TFC_READ_ZERO;
        next_s.rdData[`TFC_ST_INSYNC] = s.inSync;
        next_s.rdData[`TFC_ST_FALLBACK] = s.useRecovered;
      end
      `TFC_ADDR_RX_SYNC: next_s.rdData = s.cfg.rxSync;
      `TFC_ADDR_RX_OPT: next_s.rdData = s.cfg.rxOpt;
      `TFC_ADDR_TX_FMT: next_s.rdData = s.cfg.txFmt;
      `TFC_ADDR_COMMON1: next_s.rdData = s.cfg.common1;
      `TFC_ADDR_COMMON2: next_s.rdData = s.cfg.common2;
      default: next_s.rdData = `TFC_READ_ZERO;
    endcase
    // the transmit clock is far slower than ours, so it is simply sampled
    next_s.txClkS = {s.txClkS[1:0], transmitLineClock};
    if (s.txClkS[1] == s.txClkS[2]) begin
      next_s.txClkLevel = s.txClkS[2];
    end
    if (next_s.txClkLevel != s.txClkLevel) begin
      next_s.stallCnt = '0;
    end else if (s.stallCnt != 16'(STALL_CYC)) begin
      next_s.stallCnt = s.stallCnt + 16'h0001;
    end
    // switch only when enabled and the clock has stopped
    next_s.useRecovered = s.cfg.txFmt[`TFC_TX_FALLBACK] && (s.stallCnt == 16'(STALL_CYC));
    next_s.syncS = {s.syncS[1:0], rxStat.inSync};
    if (s.syncS[1] == s.syncS[2]) begin
      next_s.inSync = s.syncS[2];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.pinS1 <= '1;
      s.pinS2 <= '1;
      s.pinS3 <= '1;
      s.pin <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign busDataOut = s.rdData;
  assign busDataOe = !s.pin.chipSelectN && !s.pin.readN;
  assign txUseRecovered = s.useRecovered;

  // ----------------------------------------
  // link domain reset
  // ----------------------------------------
  // reset is caught by line clock edges, so the line clock must run during reset
  logic [2:0] lineRstS;
  logic lineRst;
  always_ff @(posedge lineClock) begin
    lineRstS <= {lineRstS[1:0], rst};
  end
  assign lineRst = lineRstS[2] || lineRstS[1];

  // ----------------------------------------
  // link domain state
  // ----------------------------------------
  typedef struct packed {
    tfc_cfg_t cfgS1;
    tfc_cfg_t cfgS2;
    tfc_cfg_t cfgS3;
    tfc_cfg_t cfg;
    tfc_state_t state;
    logic [5:0] hist;
    logic [4:0] qualCnt;
    logic [CNT_W-1:0] lcv;
    logic [CNT_W-1:0] pcv;
    logic [CNT_W-1:0] mos;
    logic syncOut;
    logic stretch;
    logic [2:0] pinS;
    logic pinLevel;
    logic [2:0] codeIdx;
    logic allZeroAcc;
    logic yellow;
    logic oof;
    logic resyncStart;
    logic [7:0] subByte;
    tfc_tx_ctl_t tx;
    logic amiPhase;
    logic pos;
    logic neg;
  } tfc_link_t;

  tfc_link_t l, next_l;
  logic manual;
  logic autoOn;
  logic oofDet;
  logic [5:0] newHist;
  logic [4:0] qualTarget;
  logic esf;
  logic syncDirIn;
  logic chanTransp;

  function automatic logic [2:0] count_errors(input logic [5:0] h, input logic [2:0] win);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < win && h[i]) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction : count_errors

  function automatic logic [7:0] milliwatt(input logic [2:0] idx);
    logic [7:0] b;
    unique case (idx)
      3'h0, 3'h3: b = 8'h1E;
      3'h1, 3'h2: b = 8'h0B;
      3'h4, 3'h7: b = 8'h9E;
      default: b = 8'h8B;
    endcase
    return b;
  endfunction : milliwatt

  always_comb begin
    next_l = l;
    manual = 1'b0;
    next_l.cfgS1 = s.cfg;
    next_l.cfgS2 = l.cfgS1;
    next_l.cfgS3 = l.cfgS2;
    if (l.cfgS2 == l.cfgS3) begin
      next_l.cfg = l.cfgS3;
      manual = l.cfgS3.resyncTog != l.cfg.resyncTog;
    end
    esf = l.cfg.common2[`TFC_C2_RFM];
    autoOn = !l.cfg.rxSync[`TFC_RS_AUTODIS];
    newHist = rxEv.fbitValid ? {l.hist[4:0], rxEv.fbitErr} : l.hist;
    oofDet = (l.state == TFC_INSYNC) && rxEv.fbitValid && (count_errors(newHist,
      l.cfg.rxSync[`TFC_RS_OOFB] ? `TFC_OOF_WIN_C :
      (l.cfg.rxSync[`TFC_RS_OOFA] ? `TFC_OOF_WIN_B : `TFC_OOF_WIN_A)) >= `TFC_OOF_ERRS);
    qualTarget = l.cfg.rxSync[`TFC_RS_SYNC_TIME] ? `TFC_QUAL_LONG : `TFC_QUAL_SHORT;
    next_l.hist = newHist;
    next_l.oof = oofDet;
    next_l.resyncStart = 1'b0;
    unique case (l.state)
      TFC_SEARCH: begin
        if (rxEv.candidateFound) begin
          next_l.state = TFC_QUALIFY;
          next_l.qualCnt = '0;
        end
      end
      TFC_QUALIFY: begin
        if (rxEv.fbitValid) begin
          if (rxEv.fbitErr) begin
            next_l.state = TFC_SEARCH;
          end else if (l.qualCnt + 5'h01 == qualTarget) begin
            // ESF with criteria set also needs the CRC6 check
            if (esf && l.cfg.rxSync[`TFC_RS_SYNC_CRITERIA] && !rxEv.crcMatch) begin
              next_l.state = TFC_SEARCH;
            end else begin
              next_l.state = TFC_INSYNC;
              next_l.hist = '0;
            end
          end else begin
            next_l.qualCnt = l.qualCnt + 5'h01;
          end
        end
      end
      TFC_INSYNC: begin
        // carrier loss counts unless criteria restricts to out-of-frame
        if (autoOn && (oofDet || (!l.cfg.rxSync[`TFC_RS_CRIT] && rxEv.carrierLoss))) begin
          next_l.state = TFC_SEARCH;
          next_l.resyncStart = 1'b1;
        end
      end
      default: next_l.state = TFC_SEARCH;
    endcase
    if (manual) begin
      next_l.state = TFC_SEARCH;
      next_l.resyncStart = 1'b1;
    end
    if (rxEv.lcvPulse || (l.cfg.rxSync[`TFC_RS_VCF] && rxEv.exzPulse)) begin
      next_l.lcv = l.lcv + 1'b1;
    end
    if (rxEv.fbitValid && rxEv.fbitErr && (!rxEv.fbitIsFs || l.cfg.rxOpt[`TFC_RO_FSREP])) begin
      next_l.pcv = l.pcv + 1'b1;
    end
    if (l.cfg.rxOpt[`TFC_RO_MFCF] ? (rxEv.multiframePulse && l.state != TFC_INSYNC)
        : (rxEv.fbitValid && rxEv.fbitErr)) begin
      next_l.mos = l.mos + 1'b1;
    end
    next_l.syncOut = (l.cfg.rxOpt[`TFC_RO_MODE] ? rxEv.multiframePulse : rxEv.framePulse) || l.stretch;
    next_l.stretch = !l.cfg.rxOpt[`TFC_RO_MODE] && l.cfg.rxOpt[`TFC_RO_DWIDE] && rxEv.framePulse
      && rxEv.signallingFrame;
    next_l.pinS = {l.pinS[1:0], receiveSyncPinIn};
    if (l.pinS[1] == l.pinS[2]) begin
      next_l.pinLevel = l.pinS[2];
    end
    if (rxEv.chanStrobe) begin
      next_l.codeIdx = l.codeIdx + 3'h1;
    end
    next_l.subByte = l.cfg.rxOpt[`TFC_RO_CODE] ? milliwatt(l.codeIdx) : `TFC_IDLE_CODE;
    if (rxEv.bit2Strobe && rxEv.bit2Value) begin
      next_l.allZeroAcc = 1'b0;
    end
    if (rxEv.framePulse) begin
      next_l.allZeroAcc = 1'b1;
      if (!l.cfg.rxOpt[`TFC_RO_YEL]) begin
        next_l.yellow = l.allZeroAcc && !esf;
      end
    end
    if (l.cfg.rxOpt[`TFC_RO_YEL] && rxEv.frame12SBitValid) begin
      next_l.yellow = rxEv.sBitValue && !esf;
    end
    if (esf) begin
      next_l.yellow = 1'b0;
    end
    chanTransp = (txIn.channel < 5'(`TFC_CHANNELS)) ? txIn.transparent[txIn.channel] : 1'b0;
    next_l.tx.framingFromSerial = l.cfg.txFmt[`TFC_TX_FPT];
    next_l.tx.crcFromSerial = l.cfg.txFmt[`TFC_TX_CPT];
    next_l.tx.insertSignalling = l.cfg.txFmt[`TFC_TX_ROBBED_BIT_SIGNALLING_ENABLE] && !chanTransp;
    next_l.tx.stuffBit7 = txIn.chanAllZero && (l.cfg.txFmt[`TFC_TX_GSTUFF] || chanTransp);
    next_l.tx.linkBit = l.cfg.txFmt[`TFC_TX_LINKSRC] ? txIn.linkPinBit : txIn.fdlRegBit;
    next_l.tx.sendYellow = l.cfg.txFmt[`TFC_TX_YEL];
    if (l.cfg.txFmt[`TFC_TX_BLUE]) begin
      next_l.amiPhase = !l.amiPhase;
      next_l.pos = !l.amiPhase;
      next_l.neg = l.amiPhase;
    end else begin
      next_l.pos = txIn.posIn;
      next_l.neg = txIn.negIn;
    end
  end

  always_ff @(posedge lineClock) begin
    if (lineRst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // input only with elastic store on
  assign syncDirIn = l.cfg.rxOpt[`TFC_RO_DIR] && l.cfg.common1[`TFC_C1_RESE];
  assign receiveSyncPinOe = !syncDirIn;
  assign receiveSyncPinOut = l.syncOut;
  assign rxStat = '{inSync: l.state == TFC_INSYNC,
    searchMode: tfc_search_t'({esf, l.cfg.rxSync[`TFC_RS_SYNC_CRITERIA]}),
    resyncStart: l.resyncStart, outOfFrame: l.oof,
    zbtsiEnable: l.cfg.rxOpt[`TFC_RO_ZBTSI],
    yellowAlarm: l.yellow, subByte: l.subByte, syncLevelIn: l.pinLevel};
  assign lcvCount = l.lcv;
  assign pathCount = l.pcv;
  assign multiframeCount = l.mos;
  assign txCtl = l.tx;
  assign lineOutPositive = l.pos;
  assign lineOutNegative = l.neg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_exz_counted: assert property (@(posedge lineClock) disable iff (lineRst)
    (rxEv.exzPulse && !rxEv.lcvPulse && l.cfg.rxSync[`TFC_RS_VCF]) |=> lcvCount == $past(lcvCount) + 1'b1)
    else $error("excessive zero not counted");
  a_carrier_resync: assert property (@(posedge lineClock) disable iff (lineRst)
    (l.state == TFC_INSYNC && autoOn && !l.cfg.rxSync[`TFC_RS_CRIT] && rxEv.carrierLoss)
    |=> (l.state == TFC_SEARCH && l.resyncStart))
    else $error("carrier loss did not resync");
  a_oof_resync: assert property (@(posedge lineClock) disable iff (lineRst)
    (oofDet && autoOn) |=> (rxStat.outOfFrame && l.state == TFC_SEARCH))
    else $error("out of frame did not resync");
  a_auto_held: assert property (@(posedge lineClock) disable iff (lineRst)
    (l.state == TFC_INSYNC && !autoOn && !manual) |=> l.state == TFC_INSYNC)
    else $error("resync while auto disabled");
  a_qual_length: assert property (@(posedge lineClock) disable iff (lineRst)
    ($past(l.state) == TFC_QUALIFY && l.state == TFC_INSYNC) |-> $past(l.qualCnt) + 5'h01 == $past(qualTarget))
    else $error("sync declared at wrong count");
  a_manual_restart: assert property (@(posedge lineClock) disable iff (lineRst)
    manual |=> (l.state == TFC_SEARCH && rxStat.resyncStart))
    else $error("manual resync missed");
  a_idle_code: assert property (@(posedge lineClock) disable iff (lineRst)
    !l.cfg.rxOpt[`TFC_RO_CODE] |=> rxStat.subByte == `TFC_IDLE_CODE)
    else $error("idle code wrong");
  a_no_signalling: assert property (@(posedge lineClock) disable iff (lineRst)
    !l.cfg.txFmt[`TFC_TX_ROBBED_BIT_SIGNALLING_ENABLE] |=> !txCtl.insertSignalling)
    else $error("signalling inserted while disabled");
  a_blue_ones: assert property (@(posedge lineClock) disable iff (lineRst)
    l.cfg.txFmt[`TFC_TX_BLUE] [*2] |=> (lineOutPositive ^ lineOutNegative) && (lineOutPositive != $past(lineOutPositive)))
    else $error("blue alarm not all ones");
  a_no_fallback: assert property (@(posedge clock) disable iff (rst)
    !s.cfg.txFmt[`TFC_TX_FALLBACK] |=> !txUseRecovered)
    else $error("fallback while disabled");

endmodule : tfc_framer_control

// ==== tb/tfc_line_partner.sv ====
// line interface partner: line clock, transmit clock and per-cycle line events
`timescale 1ns/10ps

module tfc_line_partner import tfc_pkg::*; (
  // clocks toward the framer
  output logic lineClock,
  output logic transmitLineClock,
  // line-side events
  output tfc_rx_ev_t rxEv,
  output tfc_tx_in_t txIn,
  // test control
  input wire logic stallTx
);
  // odd start offset keeps the line clock unrelated to the system clock
  initial begin
    lineClock = 1'b0;
    transmitLineClock = 1'b0;
    rxEv = '0;
    txIn = '0;
    #3;
    forever #40 lineClock = ~lineClock;
  end

  // a failed transmit source simply stops toggling
  always #35 if (!stallTx) transmitLineClock = ~transmitLineClock;

  // events stand one line clock; transmit inputs stand until replaced
  task automatic send(input tfc_rx_ev_t ev, input tfc_tx_in_t ti);
    @(posedge lineClock);
    #1;
    rxEv = ev;
    txIn = ti;
    @(posedge lineClock);
    #1;
    rxEv = '0;
  endtask : send
endmodule : tfc_line_partner

// ==== tb/tb.sv ====
// self-checking bench for the t1 framer control block
`timescale 1ns/10ps
`include "tfc_regs.svh"

module tb import tfc_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic csN = 1'b1;
  logic rdN = 1'b1;
  logic wrN = 1'b1;
  logic stallTx = 1'b0;
  logic syncIn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] dIn = 8'h00;
  logic [7:0] dOut;
  logic dOe, txUseRecovered, lineClock, transmitLineClock, syncOut, syncOe, pos, neg;
  logic [15:0] lcvCount, pathCount, mfCount;
  tfc_rx_ev_t rxEv;
  tfc_tx_in_t txIn;
  tfc_rx_stat_t rxStat;
  tfc_tx_ctl_t txCtl;
  int fails = 0;
  int checksDone = 0;
  int resyncSeen = 0;

  always #2.5 clock = ~clock;

  tfc_line_partner p_u (.lineClock(lineClock), .transmitLineClock(transmitLineClock), .rxEv(rxEv),
    .txIn(txIn), .stallTx(stallTx));

  // short stall window keeps the fallback test brief
  tfc_framer_control #(.STALL_CYC(20)) dut_u (.clock(clock), .rst(rst), .busChipSelectN(csN),
    .busReadN(rdN), .busWriteN(wrN), .busAddr(addr), .busDataIn(dIn), .busDataOut(dOut),
    .busDataOe(dOe), .transmitLineClock(transmitLineClock), .txUseRecovered(txUseRecovered),
    .lineClock(lineClock), .rxEv(rxEv), .txIn(txIn), .receiveSyncPinIn(syncIn),
    .receiveSyncPinOut(syncOut), .receiveSyncPinOe(syncOe), .rxStat(rxStat), .lcvCount(lcvCount),
    .pathCount(pathCount), .multiframeCount(mfCount), .txCtl(txCtl), .lineOutPositive(pos),
    .lineOutNegative(neg));

  always @(posedge lineClock) if (rxStat.resyncStart === 1'b1) resyncSeen++;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // strobes held well past the pin synchronisers, then a long gap
  task automatic busCycle(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    addr = a;
    dIn = w ? d : ~d;
    csN = 1'b0;
    wrN = ~w;
    rdN = w;
    repeat (12) @(posedge clock);
    q = dOut;
    if (!w) chk("busDataOe", 1, dOe);
    #1;
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    dIn = ~dIn;
    repeat (10) @(posedge clock);
  endtask : busCycle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    busCycle(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] q;
    busCycle(1'b0, a, 8'h00, q);
    chk(name, exp, q);
  endtask : rd

  task automatic lineWait(input int n);
    repeat (n) @(posedge lineClock);
    #1;
  endtask : lineWait

  function automatic tfc_tx_ctl_t expTx(input logic [7:0] f, input tfc_tx_in_t t);
    expTx = '{f[6], f[5], f[4] & ~t.transparent[t.channel], t.chanAllZero & (f[3] | t.transparent[t.channel]),
      f[2] ? t.linkPinBit : t.fdlRegBit, f[0]};
  endfunction : expTx

  task automatic testDone();
    $display("checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : testDone

  initial begin
    #200_000;
    fails++;
    testDone();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] regA [3];
    logic [7:0] regM [3];
    logic [7:0] mwExp [8];
    tfc_rx_ev_t ev;
    tfc_tx_in_t ti;
    int lcvExp;
    int n0;
    int n1;
    int n2;
    regA = '{`TFC_ADDR_RX_SYNC, `TFC_ADDR_RX_OPT, `TFC_ADDR_TX_FMT};
    regM = '{8'hFE, 8'hD7, 8'h7F};
    mwExp = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
    ti = '0;
    lcvExp = 0;
    v = $urandom(32'h8438);
    // line side needs the reset too, so it spans line clocks as well
    repeat (8) @(posedge clock);
    repeat (4) @(posedge lineClock);
    @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      rd(regA[i], `TFC_RESET_VALUE, "resetValue");
      v = 8'($urandom) & regM[i];
      wr(regA[i], v);
      rd(regA[i], v, "readBack");
    end
    wr(8'h3F, 8'hA5);
    rd(8'h3F, `TFC_READ_ZERO, "unmapped");
    $display("test registers done");
    wr(`TFC_ADDR_RX_SYNC, 8'h00);
    lineWait(8);
    n0 = resyncSeen;
    wr(`TFC_ADDR_RX_SYNC, 8'h01);
    lineWait(8);
    chk("resyncCount", n0 + 1, resyncSeen);
    wr(`TFC_ADDR_RX_SYNC, 8'h01);
    lineWait(8);
    chk("resyncCount", n0 + 1, resyncSeen);
    $display("test manual resync done");
    for (int k = 0; k < 2; k++) begin
      wr(`TFC_ADDR_RX_SYNC, k == 1 ? 8'h81 : 8'h01);
      lineWait(8);
      repeat (12) begin
        v = 8'($urandom);
        ev = '0;
        ev.lcvPulse = v[0];
        ev.exzPulse = v[1] & ~v[0];
        lcvExp += (v[0] | (k == 1 && v[1])) ? 1 : 0;
        p_u.send(ev, ti);
      end
      lineWait(3);
      chk("lcvCount", lcvExp, lcvCount);
    end
    $display("test violation counter done");
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 8'h7F : (k == 1) ? 8'h00 : 8'($urandom) & 8'h7F;
      ti = 34'({$urandom, $urandom});
      ti.channel = 5'($urandom_range(23));
      wr(`TFC_ADDR_TX_FMT, v);
      p_u.send('0, ti);
      lineWait(6);
      chk("txCtl", expTx(v, ti), txCtl);
      if (v[1]) chk("blueMark", 1, pos ^ neg);
      else chk("linePass", {ti.posIn, ti.negIn}, {pos, neg});
    end
    $display("test transmit controls done");
    for (int k = 0; k < 2; k++) begin
      wr(`TFC_ADDR_TX_FMT, k == 1 ? 8'h80 : 8'h00);
      stallTx = 1'b1;
      repeat (60) @(posedge clock);
      #1;
      chk("txUseRecovered", k, txUseRecovered);
      stallTx = 1'b0;
      repeat (60) @(posedge clock);
      #1;
      chk("txUseRecovered", 0, txUseRecovered);
    end
    $display("test clock fallback done");
    for (int k = 0; k < 6; k++) begin
      wr(`TFC_ADDR_COMMON1, {5'h00, k[0], 2'h0});
      // double-wide kept off; sync input only with the elastic store on
      v = 8'($urandom) & 8'hD7;
      v[3] = k[0] & k[1];
      if (k == 0) v[7] = 1'b0;
      wr(`TFC_ADDR_RX_OPT, v);
      syncIn = v[0];
      lineWait(8);
      chk("zbtsiEnable", v[6], rxStat.zbtsiEnable);
      chk("syncPinOe", !v[3], syncOe);
      chk("syncLevelIn", v[0], rxStat.syncLevelIn);
      if (!v[7]) chk("subByte", `TFC_IDLE_CODE, rxStat.subByte);
    end
    $display("test receive options done");
    wr(`TFC_ADDR_RX_OPT, 8'h00);
    wr(`TFC_ADDR_COMMON2, 8'h00);
    // k=0 out-of-frame resync, k=1 auto resync off, k=2 carrier loss after a manual restart
    for (int k = 0; k < 3; k++) begin
      wr(`TFC_ADDR_RX_SYNC, k == 1 ? 8'h02 : 8'(k / 2));
      lineWait(8);
      n0 = resyncSeen;
      n1 = pathCount;
      n2 = mfCount;
      ev = '0;
      ev.candidateFound = 1'b1;
      p_u.send(ev, ti);
      ev = '0;
      ev.fbitValid = 1'b1;
      repeat (9) p_u.send(ev, ti);
      lineWait(2);
      chk("inSyncEarly", 0, rxStat.inSync);
      p_u.send(ev, ti);
      lineWait(2);
      chk("inSync", 1, rxStat.inSync);
      ev.fbitErr = (k < 2);
      ev.carrierLoss = (k == 2);
      repeat (2) p_u.send(ev, ti);
      lineWait(2);
      chk("inSyncAfter", k == 1, rxStat.inSync);
      chk("resyncCount", n0 + (k != 1), resyncSeen);
      chk("pathCount", n1 + ((k < 2) ? 2 : 0), pathCount);
      chk("mfCount", n2 + ((k < 2) ? 2 : 0), mfCount);
    end
    wr(`TFC_ADDR_COMMON2, 8'h08);
    wr(`TFC_ADDR_RX_SYNC, 8'h08);
    lineWait(8);
    chk("searchMode", TFC_ESF_CRC, rxStat.searchMode);
    ev = '0;
    ev.candidateFound = 1'b1;
    p_u.send(ev, ti);
    ev = '0;
    ev.fbitValid = 1'b1;
    repeat (10) p_u.send(ev, ti);
    lineWait(2);
    chk("crcGate", 0, rxStat.inSync);
    $display("test sync done");
    for (int k = 0; k < 2; k++) begin
      wr(`TFC_ADDR_RX_OPT, k == 1 ? 8'h20 : 8'h00);
      lineWait(8);
      ev = '0;
      ev.framePulse = 1'b1;
      ev.signallingFrame = 1'b1;
      p_u.send(ev, ti);
      chk("syncOut", 1, syncOut);
      lineWait(1);
      chk("syncWide", k, syncOut);
    end
    wr(`TFC_ADDR_RX_OPT, 8'h80);
    lineWait(8);
    ev = '0;
    ev.chanStrobe = 1'b1;
    for (int k = 1; k < 10; k++) begin
      p_u.send(ev, ti);
      lineWait(1);
      chk("milliwatt", mwExp[k % 8], rxStat.subByte);
    end
    $display("test sync pin and code done");
    testDone();
  end
endmodule : tb
